// ---- scc_pkg.sv ----
// Constants for the serializer control-channel configuration slice
package scc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_GEN_CFG = 8'h03;
  localparam logic [7:0] ADDR_MODE_SELECT = 8'h04;
  localparam logic [7:0] ADDR_I2C_CONTROL = 8'h05;
  localparam logic [7:0] ADDR_REMOTE_ID = 8'h06;
  localparam logic [7:0] ADDR_CRC_LSB = 8'h0a;
  localparam logic [7:0] ADDR_CRC_MSB = 8'h0b;
  // Field positions
  localparam int BIT_PCLK_AUTO = 1;
  localparam int BIT_FAILSAFE = 7;
  localparam int BIT_CRC_CLEAR = 5;
  localparam int BIT_SDA_DLY_LO = 3;
  localparam int BIT_LOCAL_WR_BLOCK = 2;
  localparam int BIT_WD_SPEEDUP = 1;
  localparam int BIT_WD_DISABLE = 0;
  localparam int BIT_ID_LO = 1;
  localparam int BIT_ID_HOLD = 0;
  // Reset values
  localparam logic RST_PCLK_AUTO = 1'b1;
  localparam logic [7:0] RST_MODE_SELECT = 8'h80;
  localparam logic [7:0] RST_I2C_CONTROL = 8'h00;
  localparam logic [7:0] RST_REMOTE_ID = 8'h00;
  localparam logic [15:0] CRC_MAX = 16'hffff;
  // Clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  localparam int WD_LONG_S = 1;
  localparam int WD_SHORT_US = 50;
  localparam int WD_LONG_CYCLES = WD_LONG_S * CLK_HZ;
  localparam int WD_SHORT_CYCLES = (WD_SHORT_US * (CLK_HZ / 1_000_000));
  localparam int WD_CNT_W = 24;
  localparam int RECOVER_HALF_US = 5;
  localparam int RECOVER_HALF_CYCLES = RECOVER_HALF_US * (CLK_HZ / 1_000_000);
  localparam int RECOVER_PULSES = 9;
  localparam int SDA_DLY_BASE_NS = 240;
  localparam int SDA_DLY_STEP_NS = 40;
  localparam int SDA_DLY_MAX = (SDA_DLY_BASE_NS + 3 * SDA_DLY_STEP_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ---- scc_wd_if.sv ----
// Signals between the register slice and the bus watchdog
`timescale 1ns/100ps
interface scc_wd_if;
  logic wd_disable;
  logic wd_speedup;
  logic scl_s;
  logic sda_s;
  logic bus_free;
  logic recovering;
  logic scl_drive;
  modport ctrl (output wd_disable, output wd_speedup, output scl_s, output sda_s,
    input bus_free, input recovering, input scl_drive);
  modport wd (input wd_disable, input wd_speedup, input scl_s, input sda_s,
    output bus_free, output recovering, output scl_drive);
endinterface

// ---- scc_sda_delay.sv ----
// Delays the SDA drive request by the programmed output delay
`timescale 1ns/100ps
module scc_sda_delay (
  input wire logic ref_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [1:0] dly_sel, // Delay code
  input wire logic drive_in, // Undelayed SDA low request
  output logic drive_out // Delayed SDA low request
);
  logic [scc_pkg::SDA_DLY_MAX-1:0] taps;
  logic [scc_pkg::SDA_DLY_MAX-1:0] next_taps;
  logic next_drive_out;
  int dly_ns;
  int dly_cyc;

  // Delay in ns rounded up to whole cycles
  always_comb
  begin
    dly_ns = scc_pkg::SDA_DLY_BASE_NS + scc_pkg::SDA_DLY_STEP_NS * int'(dly_sel);
    dly_cyc = (dly_ns + scc_pkg::CLK_NS - 1) / scc_pkg::CLK_NS;
    next_taps = {taps[scc_pkg::SDA_DLY_MAX-2:0], drive_in};
    next_drive_out = taps[dly_cyc-2];
  end

  // Tap line and output flop
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      taps <= '0;
      drive_out <= 1'b0;
    end
    else
    begin
      taps <= next_taps;
      drive_out <= next_drive_out;
    end
  end
endmodule

// ---- scc_watchdog.sv ----
// Bus inactivity watchdog with nine-clock recovery
`timescale 1ns/100ps
module scc_watchdog #(
  parameter int LONG_CYCLES = scc_pkg::WD_LONG_CYCLES
) (
  input wire logic ref_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  scc_wd_if.wd wd // Config in, status out
);
  typedef enum logic [0:0] {WD_WATCH, WD_RECOVER} scc_wd_state_t;
  scc_wd_state_t state, next_state;
  logic [scc_pkg::WD_CNT_W-1:0] cnt, next_cnt, limit;
  logic [7:0] half, next_half;
  logic [3:0] pulses, next_pulses;
  logic scl_q, sda_q, next_bus_free, next_scl_drive, transition;

  // Timer, timeout decision and recovery clocking
  always_comb
  begin
    transition = (wd.scl_s != scl_q) || (wd.sda_s != sda_q);
    limit = wd.wd_speedup ? scc_pkg::WD_CNT_W'(scc_pkg::WD_SHORT_CYCLES)
                          : scc_pkg::WD_CNT_W'(LONG_CYCLES);
    next_state = state;
    next_cnt = cnt;
    next_half = half;
    next_pulses = pulses;
    next_bus_free = wd.bus_free && !transition && !wd.wd_disable;
    next_scl_drive = wd.scl_drive;
    case (state)
      WD_WATCH:
      begin
        next_scl_drive = 1'b0;
        if (wd.wd_disable || transition)
          next_cnt = '0;
        else if (cnt >= limit - 1'b1)
        begin
          next_cnt = '0;
          if (wd.sda_s)
            next_bus_free = 1'b1;
          else
          begin
            next_state = WD_RECOVER;
            next_half = '0;
            next_pulses = '0;
            next_scl_drive = 1'b1;
          end
        end
        else
          next_cnt = cnt + 1'b1;
      end
      WD_RECOVER:
      begin
        next_cnt = '0;
        if (wd.wd_disable)
        begin
          next_state = WD_WATCH;
          next_scl_drive = 1'b0;
        end
        else if (half == 8'(scc_pkg::RECOVER_HALF_CYCLES - 1))
        begin
          next_half = '0;
          next_scl_drive = !wd.scl_drive;
          if (wd.scl_drive)
          begin
            next_pulses = pulses + 1'b1;
            if (pulses == 4'(scc_pkg::RECOVER_PULSES - 1))
              next_state = WD_WATCH;
          end
        end
        else
          next_half = half + 1'b1;
      end
      default:
        next_state = WD_WATCH;
    endcase
  end

  // Watchdog state registers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state <= WD_WATCH;
      cnt <= '0;
      half <= '0;
      pulses <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      wd.bus_free <= 1'b0;
      wd.scl_drive <= 1'b0;
      wd.recovering <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      half <= next_half;
      pulses <= next_pulses;
      scl_q <= wd.scl_s;
      sda_q <= wd.sda_s;
      wd.bus_free <= next_bus_free;
      wd.scl_drive <= next_scl_drive;
      wd.recovering <= (next_state == WD_RECOVER);
    end
  end
endmodule

// ---- scc_top.sv ----
// Configuration registers of the serializer control-channel slice
// What this block does
// - Fallback bit set: pixel clock loss switches timing to internal oscillator.
// - Mode bit 7 picks failsafe level: 0 high, 1 low; reset 0x80.
// - Mode bit 5 clears CRC counters; hardware never clears that bit.
// - SDA delay code in bits 4:3 gives 240 to 360 ns.
// - Local-write-block bit rejects remote writes to local registers.
// - Remote accesses to local-side bus slaves pass regardless of that bit.
// - Control bit 1 selects watchdog timeout: 0 about 1 s, 1 about 50 us.
// - Control bit 0 set disables the bus watchdog.
// - Timeout with SDA high marks the bus free.
// - Timeout with SDA low drives nine recovery clocks on SCL.
// - Remote-ID bits 7:1 hold deserializer address; zero disables access.
// - On receive lock the channel loads the remote address unless held.
// - Remote-ID bit 0 set blocks auto-loading and keeps written value.
// - Per-port fields follow the second port select control.
// - Sixteen-bit CRC error counters read as two bytes, cleared by bit 5.
`timescale 1ns/100ps
module scc_top #(
  parameter int WD_LONG_CYCLES = scc_pkg::WD_LONG_CYCLES // About 1 s of silence
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic loc_req, // Local host access strobe
  input wire logic loc_wr, // Local access is a write
  input wire logic [7:0] loc_addr, // Local register offset
  input wire logic [7:0] loc_wdata, // Local write data
  output logic loc_ack, // Local access done pulse
  output logic [7:0] loc_rdata, // Local read data
  input wire logic rem_req, // Remote host access strobe
  input wire logic rem_wr, // Remote access is a write
  input wire logic [7:0] rem_addr, // Remote register offset
  input wire logic [7:0] rem_wdata, // Remote write data
  output logic rem_ack, // Remote access done pulse
  output logic rem_err, // Remote write refused
  output logic [7:0] rem_rdata, // Remote read data
  input wire logic rem_slave_req, // Remote access to a local-side slave
  output logic rem_slave_grant, // Slave access forwarded
  input wire logic second_port_select, // Per-port fields address port 1
  input wire logic pclk_present, // Pixel clock detected, async
  input wire logic [1:0] rx_lock, // Receive lock per port, async
  input wire logic [1:0][6:0] rx_remote_addr, // Address from control channel
  input wire logic [1:0] crc_error, // Back-channel CRC error pulse per port
  input wire logic sda_drive, // Bus logic wants SDA low
  input wire logic scl_i, // SCL pin level
  input wire logic sda_i, // SDA pin level
  output logic scl_o, // SCL output level
  output logic scl_oe, // SCL driven low
  output logic sda_o, // SDA output level
  output logic sda_oe, // SDA driven low
  output logic use_internal_osc, // Timing from internal oscillator
  output logic failsafe_low, // Failsafe inputs go low
  output logic crc_clear, // CRC counters held clear
  output logic [1:0] remote_des_en, // Deserializer access allowed per port
  output logic bus_free, // Watchdog judged the bus free
  output logic bus_recovering // Recovery clocks in progress
);
  scc_wd_if wdi ();

  // Two-flop synchronisers; reset to idle pin levels so no false edge follows
  logic [4:0] sync_a, sync_b;
  logic pclk_s, scl_s, sda_s;
  logic [1:0] lock_s, lock_q;
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sync_a <= 5'h13;
      sync_b <= 5'h13;
      lock_q <= 2'h0;
    end
    else
    begin
      sync_a <= {pclk_present, rx_lock, scl_i, sda_i};
      sync_b <= sync_a;
      lock_q <= lock_s;
    end
  end
  assign pclk_s = sync_b[4];
  assign lock_s = sync_b[3:2];
  assign scl_s = sync_b[1];
  assign sda_s = sync_b[0];

  // Register state
  logic pclk_auto, next_pclk_auto;
  logic [7:0] mode_select, next_mode_select;
  logic [7:0] i2c_control, next_i2c_control;
  logic [1:0][7:0] remote_deserializer_id, next_remote_deserializer_id;
  logic [1:0][15:0] crc_cnt, next_crc_cnt;
  logic next_loc_ack, next_rem_ack, next_rem_err;
  logic [7:0] next_loc_rdata, next_rem_rdata;
  logic port;
  logic [1:0] w_en;
  logic [1:0][7:0] w_addr, w_data;
  logic local_wr_block;

  // Per-port fields follow the port select
  assign port = second_port_select;
  assign local_wr_block = i2c_control[scc_pkg::BIT_LOCAL_WR_BLOCK];

  // Read mux; unmapped offsets read as zero
  function automatic logic [7:0] scc_read(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      scc_pkg::ADDR_GEN_CFG:
        r[scc_pkg::BIT_PCLK_AUTO] = pclk_auto;
      scc_pkg::ADDR_MODE_SELECT:
        r = mode_select;
      scc_pkg::ADDR_I2C_CONTROL:
        r = i2c_control;
      scc_pkg::ADDR_REMOTE_ID:
        r = remote_deserializer_id[port];
      scc_pkg::ADDR_CRC_LSB:
        r = crc_cnt[port][7:0];
      scc_pkg::ADDR_CRC_MSB:
        r = crc_cnt[port][15:8];
      default:
        r = 8'h00;
    endcase
    return r;
  endfunction

  // Next register values; local writes land last so they win a collision
  always_comb
  begin
    next_pclk_auto = pclk_auto;
    next_mode_select = mode_select;
    next_i2c_control = i2c_control;
    next_remote_deserializer_id = remote_deserializer_id;
    next_crc_cnt = crc_cnt;
    w_en[0] = rem_req && rem_wr && !local_wr_block;
    w_addr[0] = rem_addr;
    w_data[0] = rem_wdata;
    w_en[1] = loc_req && loc_wr;
    w_addr[1] = loc_addr;
    w_data[1] = loc_wdata;
    // Auto-load on lock rise before writes, so a same-cycle write survives
    for (int p = 0; p < 2; p++)
    begin
      if (lock_s[p] && !lock_q[p] && !remote_deserializer_id[p][scc_pkg::BIT_ID_HOLD])
        next_remote_deserializer_id[p][7:1] = rx_remote_addr[p];
    end
    for (int s = 0; s < 2; s++)
    begin
      if (w_en[s])
      begin
        case (w_addr[s])
          scc_pkg::ADDR_GEN_CFG:
            next_pclk_auto = w_data[s][scc_pkg::BIT_PCLK_AUTO];
          scc_pkg::ADDR_MODE_SELECT:
          begin
            next_mode_select = 8'h00;
            next_mode_select[scc_pkg::BIT_FAILSAFE] = w_data[s][scc_pkg::BIT_FAILSAFE];
            next_mode_select[scc_pkg::BIT_CRC_CLEAR] = w_data[s][scc_pkg::BIT_CRC_CLEAR];
          end
          scc_pkg::ADDR_I2C_CONTROL:
            next_i2c_control = {3'h0, w_data[s][4:0]};
          scc_pkg::ADDR_REMOTE_ID:
            next_remote_deserializer_id[port] = w_data[s];
          default:
          begin
          end
        endcase
      end
    end
    // Counters saturate; the clear level holds them at zero
    for (int p = 0; p < 2; p++)
    begin
      if (mode_select[scc_pkg::BIT_CRC_CLEAR])
        next_crc_cnt[p] = 16'h0000;
      else if (crc_error[p] && crc_cnt[p] != scc_pkg::CRC_MAX)
        next_crc_cnt[p] = crc_cnt[p] + 16'h0001;
    end
    next_loc_ack = loc_req;
    next_loc_rdata = loc_req && !loc_wr ? scc_read(loc_addr) : 8'h00;
    next_rem_ack = rem_req;
    next_rem_err = rem_req && rem_wr && local_wr_block;
    next_rem_rdata = rem_req && !rem_wr ? scc_read(rem_addr) : 8'h00;
  end

  // Register file and access answers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pclk_auto <= scc_pkg::RST_PCLK_AUTO;
      mode_select <= scc_pkg::RST_MODE_SELECT;
      i2c_control <= scc_pkg::RST_I2C_CONTROL;
      remote_deserializer_id <= {scc_pkg::RST_REMOTE_ID, scc_pkg::RST_REMOTE_ID};
      crc_cnt <= '0;
      loc_ack <= 1'b0;
      loc_rdata <= 8'h00;
      rem_ack <= 1'b0;
      rem_err <= 1'b0;
      rem_rdata <= 8'h00;
    end
    else
    begin
      pclk_auto <= next_pclk_auto;
      mode_select <= next_mode_select;
      i2c_control <= next_i2c_control;
      remote_deserializer_id <= next_remote_deserializer_id;
      crc_cnt <= next_crc_cnt;
      loc_ack <= next_loc_ack;
      loc_rdata <= next_loc_rdata;
      rem_ack <= next_rem_ack;
      rem_err <= next_rem_err;
      rem_rdata <= next_rem_rdata;
    end
  end

  // Watchdog hookup
  assign wdi.wd_disable = i2c_control[scc_pkg::BIT_WD_DISABLE];
  assign wdi.wd_speedup = i2c_control[scc_pkg::BIT_WD_SPEEDUP];
  assign wdi.scl_s = scl_s;
  assign wdi.sda_s = sda_s;

  scc_watchdog #(
    .LONG_CYCLES(WD_LONG_CYCLES)
  ) u_watchdog (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wd(wdi.wd)
  );

  logic sda_dly;
  scc_sda_delay u_sda_delay (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .dly_sel(i2c_control[scc_pkg::BIT_SDA_DLY_LO +: 2]),
    .drive_in(sda_drive),
    .drive_out(sda_dly)
  );

  // Status and pin outputs, all registered
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      use_internal_osc <= 1'b0;
      failsafe_low <= 1'b1;
      crc_clear <= 1'b0;
      remote_des_en <= 2'h0;
      rem_slave_grant <= 1'b0;
      bus_free <= 1'b0;
      bus_recovering <= 1'b0;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      use_internal_osc <= pclk_auto && !pclk_s;
      failsafe_low <= mode_select[scc_pkg::BIT_FAILSAFE];
      crc_clear <= mode_select[scc_pkg::BIT_CRC_CLEAR];
      remote_des_en[0] <= remote_deserializer_id[0][7:1] != 7'h00;
      remote_des_en[1] <= remote_deserializer_id[1][7:1] != 7'h00;
      rem_slave_grant <= rem_slave_req;
      bus_free <= wdi.bus_free;
      bus_recovering <= wdi.recovering;
      scl_o <= 1'b0;
      scl_oe <= wdi.scl_drive;
      sda_o <= 1'b0;
      // Recovery owns the bus, so SDA is released meanwhile
      sda_oe <= sda_dly && !wdi.recovering;
    end
  end
endmodule

// ---- scc_checker.sv ----
// Port-level assertions for the control-channel configuration slice
`timescale 1ns/100ps
module scc_checker (
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic loc_req, // Local strobe
  input wire logic loc_wr, // Local write
  input wire logic [7:0] loc_addr, // Local offset
  input wire logic [7:0] loc_wdata, // Local data
  input wire logic rem_req, // Remote strobe
  input wire logic rem_wr, // Remote write
  input wire logic [7:0] rem_addr, // Remote offset
  input wire logic rem_ack, // Remote done
  input wire logic rem_err, // Remote refused
  input wire logic rem_slave_req, // Slave access in
  input wire logic rem_slave_grant, // Slave access out
  input wire logic pclk_present, // Pixel clock seen
  input wire logic sda_drive, // SDA low request
  input wire logic scl_i, // SCL level
  input wire logic sda_i, // SDA level
  input wire logic scl_oe, // SCL drive
  input wire logic sda_oe, // SDA drive
  input wire logic use_internal_osc, // Fallback clock
  input wire logic failsafe_low, // Failsafe level
  input wire logic crc_clear, // Counter clear
  input wire logic bus_free, // Bus judged free
  input wire logic bus_recovering // Recovery running
);
  logic [15:0] quiet, next_quiet;
  logic [3:0] pulses, next_pulses;
  logic scl_q, sda_q, oe_q, act_q, act, mode_wr;
  // Raw pin silence and recovery clocks; raw pins so sync latency is not trusted
  always_comb
  begin
    act = bus_recovering | scl_oe;
    mode_wr = (loc_req & loc_wr & (loc_addr == scc_pkg::ADDR_MODE_SELECT)) |
      (rem_req & rem_wr & (rem_addr == scc_pkg::ADDR_MODE_SELECT));
    next_quiet = (scl_i != scl_q || sda_i != sda_q) ? 16'h0000 : quiet + 16'h0001;
    next_pulses = act ? pulses + {3'h0, scl_oe & ~oe_q} : 4'h0;
  end
  // Helper registers
  always_ff @(posedge ref_clk)
  begin
    quiet <= rstn ? next_quiet : 16'h0000;
    pulses <= rstn ? next_pulses : 4'h0;
    act_q <= rstn & act;
    {scl_q, sda_q, oe_q} <= {scl_i, sda_i, scl_oe};
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_failsafe;
    loc_req && loc_wr && loc_addr == scc_pkg::ADDR_MODE_SELECT |=> ##1
      failsafe_low == $past(loc_wdata[7], 2);
  endproperty
  property p_clear_set;
    loc_req && loc_wr && loc_addr == scc_pkg::ADDR_MODE_SELECT |=> ##1
      crc_clear == $past(loc_wdata[5], 2);
  endproperty
  property p_clear_hold;
    !mode_wr |=> ##1 $stable(crc_clear);
  endproperty
  property p_rem_err;
    rem_err |-> rem_ack && $past(rem_req && rem_wr);
  endproperty
  property p_grant;
    rem_slave_grant == $past(rem_slave_req);
  endproperty
  property p_osc;
    pclk_present [*5] |-> !use_internal_osc;
  endproperty
  property p_sda_dly;
    sda_oe |-> $past(sda_drive, 4) || $past(sda_drive, 5);
  endproperty
  property p_free;
    $rose(bus_free) |-> sda_i && quiet > 16'h01ea;
  endproperty
  property p_recover;
    $rose(bus_recovering) |-> !sda_i && quiet > 16'h01ea;
  endproperty
  property p_nine;
    act_q && !act |-> pulses == 4'h9;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("failsafe level not from write");
  a_clear_set: assert property (p_clear_set) else $error("clear bit not from write");
  a_clear_hold: assert property (p_clear_hold) else $error("clear bit moved unwritten");
  a_rem_err: assert property (p_rem_err) else $error("refusal without remote write");
  a_grant: assert property (p_grant) else $error("slave access not forwarded");
  a_osc: assert property (p_osc) else $error("fallback with pixel clock present");
  a_sda_dly: assert property (p_sda_dly) else $error("SDA drive delay wrong");
  a_free: assert property (p_free) else $error("bus freed too early or SDA low");
  a_recover: assert property (p_recover) else $error("recovery early or SDA high");
  a_nine: assert property (p_nine) else $error("recovery clock count wrong");
  c_free: cover property ($rose(bus_free));
  c_nine: cover property (act_q && !act);
  c_refuse: cover property (rem_err);
endmodule
bind scc_top scc_checker u_chk (.*);

// ---- scc_far_model.sv ----
// Remote-side model: link lock, reported address and CRC error pulses
`timescale 1ns/100ps
module scc_far_model (
  input wire logic ref_clk, // Clock
  input wire logic [1:0] link_up, // Bring each link up
  input wire logic [1:0][6:0] own_addr, // Address each far device reports
  input wire logic [1:0] err_burst, // Emit error pulses while high
  output logic [1:0] rx_lock, // Lock per port
  output logic [1:0][6:0] rx_remote_addr, // Address per port
  output logic [1:0] crc_error // One-cycle error pulses
);
  logic [1:0][7:0] lock_dly = '0;
  // Lock lags link-up, as a slow far end would; errors every other cycle
  always @(posedge ref_clk)
  begin
    lock_dly[0] <= {lock_dly[0][6:0], link_up[0]};
    lock_dly[1] <= {lock_dly[1][6:0], link_up[1]};
    crc_error <= err_burst & ~crc_error;
  end
  // Address is garbage until locked so a premature load is visible
  assign rx_lock = {lock_dly[1][7], lock_dly[0][7]};
  assign rx_remote_addr[0] = rx_lock[0] ? own_addr[0] : ~own_addr[0];
  assign rx_remote_addr[1] = rx_lock[1] ? own_addr[1] : ~own_addr[1];
endmodule

// ---- tb_scc_top.sv ----
// Self-checking testbench for the configuration slice
`timescale 1ns/100ps
module tb_scc_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic loc_req = 1'b0, loc_wr = 1'b0, rem_req = 1'b0, rem_wr = 1'b0, rem_slave_req = 1'b0;
  logic second_port_select = 1'b0, pclk_present = 1'b1, sda_drive = 1'b0;
  logic tb_scl = 1'b1, tb_sda = 1'b1;
  logic [7:0] loc_addr = 8'h00, loc_wdata = 8'h00, rem_addr = 8'h00, rem_wdata = 8'h00;
  logic [1:0] link_up = 2'b00, err_burst = 2'b00, rx_lock, crc_error, remote_des_en;
  logic [1:0][6:0] own_addr = '0, rx_remote_addr;
  logic [7:0] loc_rdata, rem_rdata;
  logic loc_ack, rem_ack, rem_err, rem_slave_grant, scl_o, scl_oe, sda_o, sda_oe, scl_i, sda_i;
  logic use_internal_osc, failsafe_low, crc_clear, bus_free, bus_recovering;
  logic [7:0] mdl [3:6];
  logic [31:0] seed = 32'h0000004b;
  int err_count = 0, compares = 0, cyc = 0;
  // Open-drain pins with pull-ups
  assign scl_i = tb_scl & ~scl_oe;
  assign sda_i = tb_sda & ~sda_oe;
  scc_top #(.WD_LONG_CYCLES(1000)) dut_u (.*);
  scc_far_model far_u (.*);
  initial forever #50 ref_clk = ~ref_clk;
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Readback value: unimplemented bits read zero
  function automatic logic [7:0] masked(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h03: return d & 8'h02;
      8'h04: return d & 8'ha0;
      8'h05: return d & 8'h1f;
      8'h06: return d;
      default: return 8'h00;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    chk8(n, {7'h00, e}, {7'h00, s});
  endtask
  // One access; request held until the edge that takes it, answer one cycle later
  task automatic xfer(input logic rem, input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    if (rem)
      {rem_req, rem_wr, rem_addr, rem_wdata} = {1'b1, wr, a, d};
    else
      {loc_req, loc_wr, loc_addr, loc_wdata} = {1'b1, wr, a, d};
    tick(1);
    chk1("ack", 1'b1, rem ? rem_ack : loc_ack);
    q = rem ? rem_rdata : loc_rdata;
    e = rem_err;
    {loc_req, rem_req} = 2'b00;
    tick(1);
  endtask
  task automatic rd(input logic rem, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic e;
    xfer(rem, 1'b0, a, 8'h00, q, e);
    chk8("rdata", exp, q);
  endtask
  task automatic wr(input logic rem, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    xfer(rem, 1'b1, a, d, q, e);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim)
    begin
      tick(1);
      k++;
    end
  endtask
  task automatic rst_chk();
    chk1("failsafe_low", 1'b1, failsafe_low);
    chk1("scl_sda_o", 1'b0, scl_o | sda_o);
    rd(1'b0, 8'h03, 8'h02);
    rd(1'b1, 8'h04, 8'h80);
    rd(1'b0, 8'h05, 8'h00);
    rd(1'b0, 8'h0a, 8'h00);
    rd(1'b1, 8'h20, 8'h00);
    second_port_select = 1'b1;
    rd(1'b0, 8'h06, 8'h00);
    second_port_select = 1'b0;
    rd(1'b0, 8'h06, 8'h00);
    mdl = '{8'h02, 8'h80, 8'h00, 8'h00};
  endtask
  // Cycle ceiling against a hung wait
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    logic [7:0] a, d, q;
    logic r, e, blk;
    int k, n;
    tick(3);
    rstn = 1'b1;
    rst_chk();
    // Random traffic from both hosts; remote writes refused while blocked
    for (int i = 0; i < 24; i++)
    begin
      d = rnd8();
      a = 8'h03 + {6'h00, d[1:0]};
      r = d[2];
      blk = r & mdl[5][2];
      d = rnd8();
      xfer(r, 1'b1, a, d, q, e);
      chk1("rem_err", blk, e);
      if (!blk)
        mdl[a] = masked(a, d);
      rd(~r, a, mdl[a]);
    end
    // Blocked remote write while a slave access passes
    wr(1'b0, 8'h05, 8'h04);
    rem_slave_req = 1'b1;
    xfer(1'b1, 1'b1, 8'h04, 8'h20, q, e);
    chk1("rem_err", 1'b1, e);
    chk1("grant", 1'b1, rem_slave_grant);
    rem_slave_req = 1'b0;
    rd(1'b1, 8'h04, mdl[4]);
    // Second reset in mid-run
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    rst_chk();
    // Pixel clock loss with fallback on, then off
    pclk_present = 1'b0;
    tick(6);
    chk1("osc", 1'b1, use_internal_osc);
    wr(1'b0, 8'h03, 8'h00);
    tick(2);
    chk1("osc", 1'b0, use_internal_osc);
    pclk_present = 1'b1;
    // Lock loads port 0; port 1 keeps the held software value
    d = rnd8();
    own_addr = {~d[6:0], d[6:0] | 7'h01};
    second_port_select = 1'b1;
    wr(1'b0, 8'h06, 8'h2b);
    second_port_select = 1'b0;
    link_up = 2'b11;
    tick(16);
    rd(1'b0, 8'h06, {own_addr[0], 1'b0});
    chk1("des_en0", 1'b1, remote_des_en[0]);
    chk1("des_en1", 1'b1, remote_des_en[1]);
    second_port_select = 1'b1;
    rd(1'b0, 8'h06, 8'h2b);
    second_port_select = 1'b0;
    wr(1'b0, 8'h06, 8'h00);
    tick(1);
    chk1("des_en0", 1'b0, remote_des_en[0]);
    // Error count, then the level clear holds it at zero
    d = rnd8();
    n = 3 + d[2:0];
    err_burst = 2'b01;
    tick(2 * n);
    err_burst = 2'b00;
    tick(3);
    rd(1'b0, 8'h0a, n[7:0]);
    rd(1'b0, 8'h0b, 8'h00);
    second_port_select = 1'b1;
    rd(1'b0, 8'h0a, 8'h00);
    second_port_select = 1'b0;
    wr(1'b1, 8'h04, 8'ha0);
    err_burst = 2'b01;
    tick(6);
    err_burst = 2'b00;
    rd(1'b0, 8'h0a, 8'h00);
    chk1("crc_clear", 1'b1, crc_clear);
    wr(1'b0, 8'h04, 8'h80);
    chk1("crc_clear", 1'b0, crc_clear);
    // Every SDA delay code
    for (int c = 0; c < 4; c++)
    begin
      wr(1'b0, 8'h05, {3'h0, c[1:0], 3'h0});
      sda_drive = 1'b1;
      tick(1);
      sda_drive = 1'b0;
      k = 1;
      while (sda_oe !== 1'b1 && k < 20)
      begin
        tick(1);
        k++;
      end
      chk8("sda_delay", (c < 2) ? 8'h04 : 8'h05, k[7:0]);
    end
    // Short then long timeout on an idle bus
    wr(1'b0, 8'h05, 8'h02);
    wait_hi(bus_free, 700);
    chk1("bus_free", 1'b1, bus_free);
    wr(1'b0, 8'h05, 8'h00);
    tb_sda = 1'b0;
    tick(1);
    tb_sda = 1'b1;
    tick(600);
    chk1("bus_free", 1'b0, bus_free);
    wait_hi(bus_free, 600);
    chk1("bus_free", 1'b1, bus_free);
    // Disabled watchdog never frees the bus
    wr(1'b0, 8'h05, 8'h03);
    tb_sda = 1'b0;
    tick(1);
    tb_sda = 1'b1;
    tick(700);
    chk1("bus_free", 1'b0, bus_free);
    // SDA stuck low: recovery clocks counted
    wr(1'b0, 8'h05, 8'h02);
    tb_sda = 1'b0;
    wait_hi(bus_recovering, 700);
    chk1("recovering", 1'b1, bus_recovering);
    n = 0;
    r = 1'b0;
    k = 0;
    while (bus_recovering === 1'b1 && k < 1500)
    begin
      n += int'(scl_oe === 1'b1 && r !== 1'b1);
      r = scl_oe;
      tick(1);
      k++;
    end
    chk8("pulses", 8'h09, n[7:0]);
    tb_sda = 1'b1;
    summarize();
  end
endmodule
